// file: inc/sysvec_pkg.sv
// shared constants, codes, offsets and carrier structs of the system vector generator
package sysvec_pkg;

  // ====================================================================
  // vector encoding: each pending bit k stands for code k*step
  localparam int VEC_CODE_STEP = 2;
  localparam int VEC_W = 16;
  localparam logic [15:0] VEC_NONE = 16'h0000;

  // ====================================================================
  // system reset vector codes
  localparam logic [15:0] RV_BROWNOUT = 16'h0002;
  localparam logic [15:0] RV_RESET_PIN = 16'h0004;
  localparam logic [15:0] RV_SW_BOR = 16'h0006;
  localparam logic [15:0] RV_LPM_WAKE = 16'h0008;
  localparam logic [15:0] RV_SECURITY = 16'h000a;
  localparam logic [15:0] RV_SVSH = 16'h000e;
  localparam logic [15:0] RV_SW_POR = 16'h0014;
  localparam logic [15:0] RV_WDT_TIMEOUT = 16'h0016;
  localparam logic [15:0] RV_WDT_PW = 16'h0018;
  localparam logic [15:0] RV_MEMCTL_PW = 16'h001a;
  localparam logic [15:0] RV_NVM_UNCORR = 16'h001c;
  localparam logic [15:0] RV_PERIPH_FETCH = 16'h001e;
  localparam logic [15:0] RV_PMM_PW = 16'h0020;
  localparam logic [15:0] RV_LOCK_LOSS = 16'h0024;
  localparam int RST_N_SRC = 19;

  // system nmi vector codes
  localparam logic [15:0] SV_SVS_LP_ENTRY = 16'h0002;
  localparam logic [15:0] SV_NVM_UNCORR = 16'h0004;
  localparam logic [15:0] SV_VACANT = 16'h0012;
  localparam logic [15:0] SV_MBOX_IN = 16'h0014;
  localparam logic [15:0] SV_MBOX_OUT = 16'h0016;
  localparam logic [15:0] SV_NVM_CORR = 16'h0018;
  localparam int SNMI_N_SRC = 13;

  // user nmi vector codes
  localparam logic [15:0] UV_NMI_PIN = 16'h0002;
  localparam logic [15:0] UV_OSC_FAULT = 16'h0004;
  localparam int UNMI_N_SRC = 3;

  // ====================================================================
  // register indices; byte address is index times four
  localparam logic [11:0] IDX_USER_NMI_VECTOR = 12'h15a;
  localparam logic [11:0] IDX_SYSTEM_NMI_VECTOR = 12'h15c;
  localparam logic [11:0] IDX_SYSTEM_RESET_VECTOR = 12'h15e;
  localparam logic [11:0] IDX_WDT_CTL = 12'h160;
  localparam logic [11:0] IDX_WDT_INTERVAL = 12'h162;
  localparam logic [11:0] IDX_MBOX_IN = 12'h164;
  localparam logic [11:0] IDX_MBOX_OUT = 12'h166;
  localparam logic [11:0] IDX_SYS_CTL = 12'h168;
  localparam int ADDR_SHIFT = 2;

  // ====================================================================
  // watchdog control fields
  localparam int WDT_HOLD_BIT = 0;
  localparam int WDT_INTERVAL_BIT = 1;
  localparam int WDT_SEL_LSB = 2;
  localparam int WDT_CLEAR_BIT = 4;
  localparam int WDT_PW_LSB = 8;
  localparam logic [7:0] WDT_PASSWORD = 8'h5a;
  localparam logic [15:0] WDT_INTERVAL_RESET = 16'h8000;
  typedef enum logic [1:0] {WSEL_SUB_MAIN, WSEL_AUX, WSEL_VLO, WSEL_RESERVED} wdt_sel_e;

  // system control fields
  localparam int CTL_NMI_PIN_EN_BIT = 0;
  localparam int CTL_OSC_EN_BIT = 1;
  localparam int CTL_MBOX_FULL_BIT = 4;
  localparam int CTL_WDT_RUN_BIT = 5;
  localparam logic [1:0] CTL_EN_RESET = 2'h2;
  localparam logic [3:0] BE_LOW16 = 4'h3;

  // ====================================================================
  // carrier structs for event sources
  typedef struct packed {
    logic brownout;
    logic sw_bor;
    logic lpm_wake;
    logic security;
    logic svsh;
    logic sw_por;
    logic memctl_pw;
    logic nvm_uncorr;
    logic periph_fetch;
    logic pmm_pw;
    logic lock_loss;
  } rst_src_s;

  typedef struct packed {
    logic svs_lp_entry;
    logic nvm_uncorr;
    logic vacant_access;
    logic nvm_corr;
  } snmi_src_s;

  typedef struct packed {
    logic svsh_nmi;
    logic osc_fault;
  } unmi_src_s;

endpackage : sysvec_pkg

// file: verilog/vector_encoder.sv
// priority encoder turning a pending set into a vector code
`timescale 1ns/1ns
module vector_encoder import sysvec_pkg::*; #(
  parameter int N = RST_N_SRC
) (
  // pending sources, bit 0 unused (means none)
  input wire logic [N-1:0] pending,
  // encoded code and the one-hot winner
  output logic [15:0] code,
  output logic [N-1:0] grant
);

  // ====================================================================
  // lowest index wins, so walk from the top and let later hits override
  always_comb begin
    code = VEC_NONE;
    grant = '0;
    for (int i = N - 1; i >= 1; i--) begin
      if (pending[i]) begin
        code = 16'(i * VEC_CODE_STEP);
        grant = '0;
        grant[i] = 1'b1;
      end
    end
  end

endmodule : vector_encoder

// file: verilog/system_reset_nmi_vector_gen.sv
// system reset / nmi vector generator with watchdog link and debug mailbox
`timescale 1ns/1ns
module system_reset_nmi_vector_gen import sysvec_pkg::*; (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // avalon-mm slave
  input wire logic [11:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // event sources, same clock, one-cycle pulses
  input wire rst_src_s RST_SRC,
  input wire snmi_src_s SNMI_SRC,
  input wire unmi_src_s UNMI_SRC,
  // asynchronous pins
  input wire logic RESET_PIN_N,
  input wire logic NMI_PIN,
  // watchdog clock ticks from other domains (sub-main, aux, vlo)
  input wire logic [2:0] WDT_CLK_TICK,
  // debug link mailbox side
  input wire logic DBG_IN_VALID,
  input wire logic [15:0] DBG_IN_DATA,
  input wire logic DBG_OUT_TAKE,
  output logic [15:0] DBG_OUT_DATA,
  output logic DBG_OUT_FULL,
  // reset and interrupt requests
  output logic BROWNOUT_RST,
  output logic POR_RST,
  output logic CLEAR_RST,
  output logic SYS_NMI_REQ,
  output logic USER_NMI_REQ,
  output logic WDT_IRQ
);

  // ====================================================================
  // declarations
  logic [RST_N_SRC-1:0] rst_pend_q, rst_pend_d, rst_ev, rst_grant; // reset pending set
  logic [SNMI_N_SRC-1:0] snmi_pend_q, snmi_pend_d, snmi_ev, snmi_grant; // system nmi set
  logic [UNMI_N_SRC-1:0] unmi_pend_q, unmi_pend_d, unmi_ev, unmi_grant; // user nmi set
  logic [15:0] rst_code, snmi_code, unmi_code; // encoder outputs
  logic ack_q; // one wait state then answer
  logic req, take_rd, take_wr, wr_ok; // bus decode
  logic [11:0] idx; // register index from byte address
  logic [1:0] pin_sync_q, nmi_sync_q; // pin synchronisers
  logic pin_last_q, nmi_last_q; // edge detect history
  logic [2:0] tick_s1_q, tick_s2_q, tick_s3_q; // tick synchronisers
  logic [2:0] tick_rise; // synchronised tick edges
  logic [7:0] wdt_ctl_q; // hold, mode, select, kept low byte
  logic [15:0] wdt_int_q, wdt_cnt_q; // interval and counter
  logic wdt_tick, wdt_expire, wdt_pw_bad, wdt_clear; // watchdog events
  logic [1:0] ctl_en_q; // user nmi enables
  logic [15:0] mbox_in_q; // word from debug link
  logic brownout_class, por_class, clear_class; // reset classes this cycle

  // ====================================================================
  // avalon decode: every access gets exactly one wait state
  assign idx = AVS_ADDRESS >> ADDR_SHIFT;
  assign req = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack_q;
  assign take_rd = AVS_READ & ~ack_q;
  assign take_wr = AVS_WRITE & ~ack_q;
  // partial writes are ignored; registers are 16 bits wide
  assign wr_ok = take_wr && ((AVS_BYTEENABLE & BE_LOW16) == BE_LOW16);

  // ack toggles so a held request is taken once
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // read data captured at the take edge; unmapped reads give zero
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      AVS_READDATA <= '0;
    end else if (take_rd) begin
      AVS_READDATA <= '0;
      case (idx)
        IDX_USER_NMI_VECTOR: AVS_READDATA[15:0] <= unmi_code;
        IDX_SYSTEM_NMI_VECTOR: AVS_READDATA[15:0] <= snmi_code;
        IDX_SYSTEM_RESET_VECTOR: AVS_READDATA[15:0] <= rst_code;
        IDX_WDT_CTL: AVS_READDATA[7:0] <= wdt_ctl_q;
        IDX_WDT_INTERVAL: AVS_READDATA[15:0] <= wdt_int_q;
        IDX_MBOX_IN: AVS_READDATA[15:0] <= mbox_in_q;
        IDX_MBOX_OUT: AVS_READDATA[15:0] <= DBG_OUT_DATA;
        IDX_SYS_CTL: begin
          AVS_READDATA[CTL_OSC_EN_BIT:CTL_NMI_PIN_EN_BIT] <= ctl_en_q;
          AVS_READDATA[CTL_MBOX_FULL_BIT] <= DBG_OUT_FULL;
          AVS_READDATA[CTL_WDT_RUN_BIT] <= ~wdt_ctl_q[WDT_HOLD_BIT];
        end
        default: AVS_READDATA <= '0;
      endcase
    end
  end

  // ====================================================================
  // pin synchronisers and falling/rising edge detect on the second flop
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_sync_q <= 2'b11;
      pin_last_q <= 1'b1;
      nmi_sync_q <= 2'b00;
      nmi_last_q <= 1'b0;
    end else begin
      pin_sync_q <= {pin_sync_q[0], RESET_PIN_N};
      pin_last_q <= pin_sync_q[1];
      nmi_sync_q <= {nmi_sync_q[0], NMI_PIN};
      nmi_last_q <= nmi_sync_q[1];
    end
  end

  // ====================================================================
  // watchdog tick synchronisers, one per clock source
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_tick
      always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
          tick_s1_q[g] <= 1'b0;
          tick_s2_q[g] <= 1'b0;
          tick_s3_q[g] <= 1'b0;
        end else begin
          tick_s1_q[g] <= WDT_CLK_TICK[g];
          tick_s2_q[g] <= tick_s1_q[g];
          tick_s3_q[g] <= tick_s2_q[g];
        end
      end
      assign tick_rise[g] = tick_s2_q[g] & ~tick_s3_q[g];
    end
  endgenerate

  // clock source select, reserved code gives no ticks
  always_comb begin
    case (wdt_sel_e'(wdt_ctl_q[WDT_SEL_LSB+1:WDT_SEL_LSB]))
      WSEL_SUB_MAIN: wdt_tick = tick_rise[0];
      WSEL_AUX: wdt_tick = tick_rise[1];
      WSEL_VLO: wdt_tick = tick_rise[2];
      default: wdt_tick = 1'b0;
    endcase
  end

  // watchdog control writes must carry the password in the upper byte
  assign wdt_pw_bad = wr_ok && (idx == IDX_WDT_CTL) &&
                      (AVS_WRITEDATA[WDT_PW_LSB+7:WDT_PW_LSB] != WDT_PASSWORD);
  assign wdt_clear = wr_ok && (idx == IDX_WDT_CTL) && !wdt_pw_bad && AVS_WRITEDATA[WDT_CLEAR_BIT];
  assign wdt_expire = wdt_tick && !wdt_ctl_q[WDT_HOLD_BIT] && (wdt_cnt_q >= wdt_int_q - 16'h0001);

  // watchdog control register; the clear bit is a strobe, not stored
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wdt_ctl_q <= '0;
      wdt_int_q <= WDT_INTERVAL_RESET;
    end else if (wr_ok && idx == IDX_WDT_CTL && !wdt_pw_bad) begin
      wdt_ctl_q <= AVS_WRITEDATA[7:0] & ~(8'h01 << WDT_CLEAR_BIT);
    end else if (wr_ok && idx == IDX_WDT_INTERVAL) begin
      wdt_int_q <= AVS_WRITEDATA[15:0];
    end
  end

  // interval counter; restarts on expiry or on a clear strobe
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wdt_cnt_q <= '0;
    end else if (wdt_clear || wdt_expire) begin
      wdt_cnt_q <= '0;
    end else if (wdt_tick && !wdt_ctl_q[WDT_HOLD_BIT]) begin
      wdt_cnt_q <= wdt_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      WDT_IRQ <= 1'b0;
    end else begin
      WDT_IRQ <= wdt_expire & wdt_ctl_q[WDT_INTERVAL_BIT];
    end
  end

  // ====================================================================
  // mailbox: debug writes land in, application writes go out
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mbox_in_q <= '0;
      DBG_OUT_DATA <= '0;
      DBG_OUT_FULL <= 1'b0;
      ctl_en_q <= CTL_EN_RESET;
    end else begin
      if (DBG_IN_VALID) begin
        mbox_in_q <= DBG_IN_DATA;
      end
      // a new word wins over a take in the same cycle
      if (wr_ok && idx == IDX_MBOX_OUT) begin
        DBG_OUT_DATA <= AVS_WRITEDATA[15:0];
        DBG_OUT_FULL <= 1'b1;
      end else if (DBG_OUT_TAKE) begin
        DBG_OUT_FULL <= 1'b0;
      end
      if (wr_ok && idx == IDX_SYS_CTL) begin
        ctl_en_q <= AVS_WRITEDATA[CTL_OSC_EN_BIT:CTL_NMI_PIN_EN_BIT];
      end
    end
  end

  // ====================================================================
  // event vectors indexed by code / step
  always_comb begin
    rst_ev = '0;
    rst_ev[RV_BROWNOUT/VEC_CODE_STEP] = RST_SRC.brownout;
    rst_ev[RV_RESET_PIN/VEC_CODE_STEP] = ~pin_sync_q[1] & pin_last_q;
    rst_ev[RV_SW_BOR/VEC_CODE_STEP] = RST_SRC.sw_bor;
    rst_ev[RV_LPM_WAKE/VEC_CODE_STEP] = RST_SRC.lpm_wake;
    rst_ev[RV_SECURITY/VEC_CODE_STEP] = RST_SRC.security;
    rst_ev[RV_SVSH/VEC_CODE_STEP] = RST_SRC.svsh;
    rst_ev[RV_SW_POR/VEC_CODE_STEP] = RST_SRC.sw_por;
    // watchdog timeout only in watchdog mode
    rst_ev[RV_WDT_TIMEOUT/VEC_CODE_STEP] = wdt_expire & ~wdt_ctl_q[WDT_INTERVAL_BIT];
    rst_ev[RV_WDT_PW/VEC_CODE_STEP] = wdt_pw_bad;
    rst_ev[RV_MEMCTL_PW/VEC_CODE_STEP] = RST_SRC.memctl_pw;
    rst_ev[RV_NVM_UNCORR/VEC_CODE_STEP] = RST_SRC.nvm_uncorr;
    rst_ev[RV_PERIPH_FETCH/VEC_CODE_STEP] = RST_SRC.periph_fetch;
    rst_ev[RV_PMM_PW/VEC_CODE_STEP] = RST_SRC.pmm_pw;
    rst_ev[RV_LOCK_LOSS/VEC_CODE_STEP] = RST_SRC.lock_loss;
  end

  always_comb begin
    snmi_ev = '0;
    // internal faults and mailbox events go to system nmi
    snmi_ev[SV_SVS_LP_ENTRY/VEC_CODE_STEP] = SNMI_SRC.svs_lp_entry;
    snmi_ev[SV_NVM_UNCORR/VEC_CODE_STEP] = SNMI_SRC.nvm_uncorr;
    snmi_ev[SV_VACANT/VEC_CODE_STEP] = SNMI_SRC.vacant_access;
    snmi_ev[SV_MBOX_IN/VEC_CODE_STEP] = DBG_IN_VALID;
    snmi_ev[SV_MBOX_OUT/VEC_CODE_STEP] = DBG_OUT_TAKE & DBG_OUT_FULL;
    snmi_ev[SV_NVM_CORR/VEC_CODE_STEP] = SNMI_SRC.nvm_corr;
  end

  always_comb begin
    unmi_ev = '0;
    // pin, supervisor and oscillator go to user nmi
    unmi_ev[UV_NMI_PIN/VEC_CODE_STEP] = ctl_en_q[CTL_NMI_PIN_EN_BIT] &
                                        ((nmi_sync_q[1] & ~nmi_last_q) | UNMI_SRC.svsh_nmi);
    unmi_ev[UV_OSC_FAULT/VEC_CODE_STEP] = ctl_en_q[CTL_OSC_EN_BIT] & UNMI_SRC.osc_fault;
  end

  // ====================================================================
  // encoders; the granted bit clears on a taken read
  vector_encoder #(.N(RST_N_SRC)) u_rst_enc (.pending(rst_pend_q), .code(rst_code), .grant(rst_grant));
  vector_encoder #(.N(SNMI_N_SRC)) u_snmi_enc (.pending(snmi_pend_q), .code(snmi_code), .grant(snmi_grant));
  vector_encoder #(.N(UNMI_N_SRC)) u_unmi_enc (.pending(unmi_pend_q), .code(unmi_code), .grant(unmi_grant));

  // a new event in the clearing cycle stays set
  always_comb begin
    rst_pend_d = rst_pend_q;
    snmi_pend_d = snmi_pend_q;
    unmi_pend_d = unmi_pend_q;
    if (take_rd && idx == IDX_SYSTEM_RESET_VECTOR) begin
      rst_pend_d = rst_pend_q & ~rst_grant;
    end
    if (take_rd && idx == IDX_SYSTEM_NMI_VECTOR) begin
      snmi_pend_d = snmi_pend_q & ~snmi_grant;
    end
    if (take_rd && idx == IDX_USER_NMI_VECTOR) begin
      unmi_pend_d = unmi_pend_q & ~unmi_grant;
    end
    rst_pend_d = rst_pend_d | rst_ev;
    snmi_pend_d = snmi_pend_d | snmi_ev;
    unmi_pend_d = unmi_pend_d | unmi_ev;
  end

  // pending sets and nmi request levels
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_pend_q <= '0;
      snmi_pend_q <= '0;
      unmi_pend_q <= '0;
      SYS_NMI_REQ <= 1'b0;
      USER_NMI_REQ <= 1'b0;
    end else begin
      rst_pend_q <= rst_pend_d;
      snmi_pend_q <= snmi_pend_d;
      unmi_pend_q <= unmi_pend_d;
      SYS_NMI_REQ <= |snmi_pend_d;
      USER_NMI_REQ <= |unmi_pend_d;
    end
  end

  // ====================================================================
  // reset class nesting
  assign brownout_class = |rst_ev[RV_SVSH/VEC_CODE_STEP:RV_BROWNOUT/VEC_CODE_STEP];
  assign por_class = brownout_class | rst_ev[RV_SW_POR/VEC_CODE_STEP];
  assign clear_class = por_class | (|rst_ev[RST_N_SRC-1:RV_WDT_TIMEOUT/VEC_CODE_STEP]);

  // one-cycle reset pulses toward the rest of the chip
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      BROWNOUT_RST <= 1'b0;
      POR_RST <= 1'b0;
      CLEAR_RST <= 1'b0;
    end else begin
      BROWNOUT_RST <= brownout_class;
      POR_RST <= por_class;
      CLEAR_RST <= clear_class;
    end
  end

  // ====================================================================
  // checks
  property p_one_wait;
    @(posedge REF_CLK) disable iff (!RST_N) (req && !ack_q) |=> !AVS_WAITREQUEST;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("bus answer not after one wait");

  property p_user_read;
    @(posedge REF_CLK) disable iff (!RST_N)
      (take_rd && idx == IDX_USER_NMI_VECTOR) |=> AVS_READDATA[15:0] == $past(unmi_code);
  endproperty
  a_user_read: assert property (p_user_read) else $error("user vector read wrong");

  property p_read_clears;
    @(posedge REF_CLK) disable iff (!RST_N)
      (take_rd && idx == IDX_SYSTEM_RESET_VECTOR && rst_code != VEC_NONE && !(|(rst_ev & rst_grant)))
      |=> (rst_pend_q & $past(rst_grant)) == '0;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read did not clear source");

  property p_brownout_top;
    @(posedge REF_CLK) disable iff (!RST_N) rst_pend_q[RV_BROWNOUT/VEC_CODE_STEP] |-> rst_code == RV_BROWNOUT;
  endproperty
  a_brownout_top: assert property (p_brownout_top) else $error("brownout not top priority");

  property p_wdt_reset;
    @(posedge REF_CLK) disable iff (!RST_N)
      (wdt_expire && !wdt_ctl_q[WDT_INTERVAL_BIT]) |=> CLEAR_RST && rst_pend_q[RV_WDT_TIMEOUT/VEC_CODE_STEP];
  endproperty
  a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog expiry gave no reset");

  property p_interval_irq;
    @(posedge REF_CLK) disable iff (!RST_N)
      (wdt_expire && wdt_ctl_q[WDT_INTERVAL_BIT]) |=> WDT_IRQ && !$rose(rst_pend_q[RV_WDT_TIMEOUT/VEC_CODE_STEP]);
  endproperty
  a_interval_irq: assert property (p_interval_irq) else $error("interval mode misbehaved");

  property p_nest;
    @(posedge REF_CLK) disable iff (!RST_N) (BROWNOUT_RST |-> POR_RST) and (POR_RST |-> CLEAR_RST);
  endproperty
  a_nest: assert property (p_nest) else $error("reset classes do not nest");

  property p_mbox_in;
    @(posedge REF_CLK) disable iff (!RST_N)
      DBG_IN_VALID |=> snmi_pend_q[SV_MBOX_IN/VEC_CODE_STEP] && mbox_in_q == $past(DBG_IN_DATA) && SYS_NMI_REQ;
  endproperty
  a_mbox_in: assert property (p_mbox_in) else $error("mailbox input lost");

  property p_osc_route;
    @(posedge REF_CLK) disable iff (!RST_N)
      (UNMI_SRC.osc_fault && ctl_en_q[CTL_OSC_EN_BIT]) |=> unmi_pend_q[UV_OSC_FAULT/VEC_CODE_STEP] && USER_NMI_REQ;
  endproperty
  a_osc_route: assert property (p_osc_route) else $error("oscillator fault not routed");

  property p_sel_reserved;
    @(posedge REF_CLK) disable iff (!RST_N)
      (wdt_ctl_q[WDT_SEL_LSB+1:WDT_SEL_LSB] == WSEL_RESERVED) |-> !wdt_tick;
  endproperty
  a_sel_reserved: assert property (p_sel_reserved) else $error("reserved clock select ticks");

endmodule : system_reset_nmi_vector_gen

// file: tb/sys_partner.sv
// far side model: watchdog tick sources and debug link end of the mailbox
`timescale 1ns/1ns
module sys_partner #(
  parameter int TAKE_DLY = 3
) (
  // clock and controls from the bench
  input wire logic clk,
  input wire logic [2:0] tick_en,
  input wire logic send,
  input wire logic [15:0] send_data,
  // mailbox out side of the device
  input wire logic [15:0] out_data,
  input wire logic out_full,
  // driven toward the device; got carries the taken word back to the bench
  output logic [2:0] ticks = 3'h0,
  output logic in_valid = 1'b0,
  output logic [15:0] in_data = 16'h0,
  output logic take = 1'b0,
  output logic [15:0] got = 16'h0
);
  int dly = 0;
  logic ph = 1'b0;
  // tick levels held two cycles; an idle source stands still
  always @(posedge clk) begin
    ph <= !ph;
    if (ph) ticks <= ticks ^ tick_en;
  end
  // word into the mailbox; data garbled when not valid
  always @(posedge clk) begin
    in_valid <= send;
    in_data <= send ? send_data : ~in_data;
  end
  // outgoing word taken late, as a slow debugger would
  always @(posedge clk) begin
    take <= 1'b0;
    if (out_full && !take) begin
      dly <= dly + 1;
      if (dly == TAKE_DLY) begin
        take <= 1'b1;
        got <= out_data;
        dly <= 0;
      end
    end
  end
endmodule : sys_partner

// file: tb/tb_top.sv
// self-checking bench for the system reset and nmi vector generator
`timescale 1ns/1ns
module tb_top import sysvec_pkg::*;;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, pin_n = 1, npin = 0, send = 0;
  logic [11:0] adr = 12'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic wq, bo, por, pc, snmi, unmi, irq, full, take, iv;
  logic [2:0] ticks, ten = 3'h0;
  logic [15:0] id, od, got, q, sd = 16'h0;
  rst_src_s rs = '0;
  snmi_src_s ss = '0;
  unmi_src_s us = '0;
  int num_errors = 0, n_compared = 0, cyc = 0, seed = 32'h90372f3e, i;
  int cnt [4] = '{0, 0, 0, 0}, c0 [4];
  wire [3:0] pl = {bo, por, pc, irq};
  // vector codes per source, in priority order
  logic [15:0] ct [3][12] = '{
    '{16'h2, 16'h4, 16'h6, 16'h8, 16'ha, 16'he, 16'h14, 16'h1a, 16'h1c, 16'h1e, 16'h20, 16'h24},
    '{16'h2, 16'h4, 16'h12, 16'h14, 16'h16, 16'h18, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0},
    '{16'h2, 16'h4, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0}};
  system_reset_nmi_vector_gen uut (.REF_CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wq), .RST_SRC(rs), .SNMI_SRC(ss), .UNMI_SRC(us), .RESET_PIN_N(pin_n),
    .NMI_PIN(npin), .WDT_CLK_TICK(ticks), .DBG_IN_VALID(iv), .DBG_IN_DATA(id), .DBG_OUT_TAKE(take),
    .DBG_OUT_DATA(od), .DBG_OUT_FULL(full), .BROWNOUT_RST(bo), .POR_RST(por), .CLEAR_RST(pc),
    .SYS_NMI_REQ(snmi), .USER_NMI_REQ(unmi), .WDT_IRQ(irq));
  sys_partner p (.clk(clk), .tick_en(ten), .send(send), .send_data(sd), .out_data(od),
    .out_full(full), .ticks(ticks), .in_valid(iv), .in_data(id), .take(take), .got(got));
  // =====================================================
  // clock, pulse counters and hang guard
  initial forever #10 clk = ~clk;
  always @(posedge clk) foreach (cnt[j]) cnt[j] <= cnt[j] + int'(pl[3 - j]);
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end
  function automatic logic hit(int j);
    return cnt[j] != c0[j];
  endfunction : hit
  task automatic check(input logic [15:0] sv, input logic [15:0] ev);
    n_compared++;
    if (sv !== ev) begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, sv, ev);
    end
  endtask : check
  // avalon master: hold until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    adr <= a;
    wdat <= {16'h0, d};
    rd <= !w;
    wr <= w;
    #1;
    while (wq !== 1'b0) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    q = rdat[15:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  // pulse a set of sources of one vector, then drain that vector
  task automatic fire(input int k, input logic [11:0] mk);
    logic [10:0] r;
    logic [15:0] w;
    logic [11:0] a;
    logic b;
    w = 16'($random(seed));
    a = 12'h578 - {k[8:0], 3'h0};
    b = |mk[5:0];
    for (int j = 0; j < 11; j++) r[10 - j] = mk[j + int'(j > 0)];
    if (k == 2) bus(1, 12'h5a0, 16'h0003);
    if (k == 1 && mk[4]) bus(1, 12'h598, w);
    @(posedge clk);
    c0 = cnt;
    if (k == 0) rs <= r;
    if (k == 0) pin_n <= !mk[1];
    if (k == 1) ss <= {mk[0], mk[1], mk[2], mk[5]};
    if (k == 1) send <= mk[3];
    sd <= w;
    if (k == 2) us <= {mk[0] & mk[2], mk[1]};
    if (k == 2) npin <= mk[0];
    @(posedge clk);
    rs <= '0;
    ss <= '0;
    us <= '0;
    send <= 1'b0;
    repeat (3) @(posedge clk);
    pin_n <= 1'b1;
    npin <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    if (k == 0) check(16'({hit(0), hit(1), hit(2)}), 16'({b, b | mk[6], b | (|mk[11:6])}));
    check(16'({snmi, unmi}), 16'({k == 1 && |mk[5:0], k == 2 && |mk[1:0]}));
    for (int j = 0; j < 12; j++) if (mk[j] && ct[k][j] != 16'h0) begin
      bus(0, a, 16'h0);
      check(q, ct[k][j]);
    end
    bus(0, a, 16'h0);
    check(q, 16'h0);
    check(16'({snmi, unmi}), 16'h0);
    if (k == 1 && mk[4]) check(got, w);
    if (k == 1 && mk[3]) bus(0, 12'h590, 16'h0);
    if (k == 1 && mk[3]) check(q, w);
    $display("event test kind %0d mask %h done", k, mk);
  endtask : fire
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  // =====================================================
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, 12'h7fc, 16'h0);
    check(q, 16'h0);
    bus(1, 12'h578, 16'h0024);
    for (i = 0; i < 3; i++) begin
      bus(0, 12'h568 + 12'(8 * i), 16'h0);
      check(q, 16'h0);
    end
    bus(1, 12'h580, 16'h0002);
    bus(0, 12'h578, 16'h0);
    check(q, 16'h0018);
    bus(1, 12'h588, 16'h0002);
    for (i = 0; i < 3; i++) begin
      bus(1, 12'h580, {8'h5a, 8'h12 | 8'(i << 2)});
      c0 = cnt;
      ten <= ~(3'h1 << i);
      repeat (60) @(posedge clk);
      check(16'(hit(3)), 16'h0);
      c0 = cnt;
      ten <= 3'h1 << i;
      repeat (60) @(posedge clk);
      check(16'({hit(3), hit(2)}), 16'h2);
      ten <= 3'h0;
      // let ticks still in the synchronisers die out
      repeat (8) @(posedge clk);
    end
    // reserved select in interval mode: no tick, no interrupt, no reset
    bus(1, 12'h580, 16'h5a1e);
    c0 = cnt;
    ten <= 3'h7;
    repeat (60) @(posedge clk);
    ten <= 3'h0;
    repeat (8) @(posedge clk);
    check(16'({hit(3), hit(2)}), 16'h0);
    bus(1, 12'h580, 16'h5a10);
    c0 = cnt;
    ten <= 3'h1;
    repeat (60) @(posedge clk);
    ten <= 3'h0;
    repeat (8) @(posedge clk);
    check(16'({hit(3), hit(2)}), 16'h1);
    bus(0, 12'h578, 16'h0);
    check(q, 16'h0016);
    $display("watchdog test done");
    for (i = 0; i < 8; i++) for (int k = 0; k < 3; k++) fire(k, i == 0 ? 12'hfff : 12'($random(seed)));
    give_verdict();
  end
endmodule : tb_top
